// file: dac_host_end.sv
// The register offsets and the Avalon-MM slave port were decided locally.
`timescale 1ns/10ps
module dac_host_end (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // Avalon-MM slave
  input wire logic [4:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Interrupt
  output logic o_irq,
  // Link pins
  dac_link_if.host link
);
  import dac_pkg::*;

  typedef enum logic [3:0] {
    H_IDLE = 4'b0001,
    H_PSTB = 4'b0010,
    H_SFRM = 4'b0100,
    H_SGAP = 4'b1000
  } host_state_t;

  host_state_t state_q;
  logic [1:0] busy_meta_q;
  logic [1:0] sdo_meta_q;
  logic busy_last_q;
  logic acc;
  logic go;
  logic rd_clr;
  logic [EVT_W-1:0] evt;
  logic [CTRL_W-1:0] ctrl_q;
  logic [31:0] data_q;
  logic [EVT_W-1:0] stat_q;
  logic [EVT_W-1:0] mask_q;
  logic [CODE_W-1:0] rdbk_q;
  logic [DIV_W-1:0] div_q;
  logic [BITCNT_W-1:0] bit_q;
  logic [FRAME_W-1:0] tx_q;
  logic [FRAME_W-1:0] rx_q;
  logic second_q;
  logic done;
  logic cs_n_q;
  logic wr_n_q;
  logic sclk_q;
  logic all_q;

  // The request is taken at the edge where waitrequest is seen low.
  assign acc = (i_avs_read || i_avs_write) && !o_avs_waitrequest;
  assign go = acc && i_avs_write && i_avs_address == REG_CTRL
              && i_avs_writedata[CTRL_GO] && state_q == H_IDLE;
  assign rd_clr = acc && i_avs_read && i_avs_address == REG_STATUS;
  assign done = (state_q == H_PSTB && div_q == STROBE_LAST)
                || (state_q == H_SGAP && div_q == HALF_LAST && !second_q);
  assign evt = {busy_meta_q[1] && !busy_last_q, done};

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      busy_meta_q <= 2'b11;
      sdo_meta_q <= 2'b00;
      busy_last_q <= 1'b1;
    end else begin
      busy_meta_q <= {busy_meta_q[0], link.busy_n};
      sdo_meta_q <= {sdo_meta_q[0], link.sdout};
      busy_last_q <= busy_meta_q[1];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h00000000;
    end else begin
      o_avs_waitrequest <= !((i_avs_read || i_avs_write)
                             && o_avs_waitrequest);
      unique case (i_avs_address)
        REG_CTRL: o_avs_readdata <= {27'h0000000, ctrl_q};
        REG_DATA: o_avs_readdata <= data_q;
        REG_STATUS: o_avs_readdata <= {22'h000000, !busy_meta_q[1],
                                       state_q != H_IDLE, 6'h00, stat_q};
        REG_MASK: o_avs_readdata <= {30'h00000000, mask_q};
        REG_RDBK: o_avs_readdata <= {18'h00000, rdbk_q};
        default: o_avs_readdata <= 32'h00000000;
      endcase
    end
  end

  // A new event in the clearing read's cycle survives the clear.
  // Only the bits that the read returned are cleared, so an event that
  // lands between the data capture and the clear is not lost.
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      ctrl_q <= 5'h00;
      data_q <= 32'h00000000;
      mask_q <= 2'h0;
      stat_q <= 2'h0;
      o_irq <= 1'b0;
    end else begin
      if (acc && i_avs_write && i_avs_address == REG_CTRL
          && state_q == H_IDLE) begin
        ctrl_q <= i_avs_writedata[CTRL_W-1:0];
      end
      if (acc && i_avs_write && i_avs_address == REG_DATA) begin
        data_q <= i_avs_writedata & 32'h001F3FFF;
      end
      if (acc && i_avs_write && i_avs_address == REG_MASK) begin
        mask_q <= i_avs_writedata[EVT_W-1:0];
      end
      stat_q <= (stat_q & ~(rd_clr ? o_avs_readdata[EVT_W-1:0] : 2'h0))
                | evt;
      o_irq <= |(stat_q & mask_q);
    end
  end

  // Serial words carry read and offset flags, channel, then code.
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state_q <= H_IDLE;
      div_q <= 4'h0;
      bit_q <= 5'h00;
      tx_q <= 24'h000000;
      rx_q <= 24'h000000;
      second_q <= 1'b0;
      rdbk_q <= 14'h0000;
      cs_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      sclk_q <= 1'b1;
      all_q <= 1'b0;
    end else begin
      div_q <= div_q + 4'h1;
      unique case (state_q)
        H_IDLE: begin
          div_q <= 4'h0;
          bit_q <= 5'h00;
          sclk_q <= 1'b1;
          tx_q <= {i_avs_writedata[CTRL_READ], i_avs_writedata[CTRL_OFFS],
                   data_q[DATA_CHAN_LSB +: ADDR_W], 3'h0,
                   data_q[CODE_W-1:0]};
          second_q <= i_avs_writedata[CTRL_READ];
          if (go) begin
            cs_n_q <= 1'b0;
            wr_n_q <= i_avs_writedata[CTRL_SERIAL];
            all_q <= i_avs_writedata[CTRL_ALL]
                     && !i_avs_writedata[CTRL_SERIAL];
            state_q <= i_avs_writedata[CTRL_SERIAL] ? H_SFRM : H_PSTB;
          end
        end
        H_PSTB: begin
          if (div_q == STROBE_LAST) begin
            cs_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            all_q <= 1'b0;
            state_q <= H_IDLE;
          end
        end
        H_SFRM: begin
          if (div_q == HALF_LAST) begin
            div_q <= 4'h0;
            sclk_q <= !sclk_q;
            if (sclk_q) begin
              rx_q <= {rx_q[FRAME_W-2:0], sdo_meta_q[1]};
              bit_q <= bit_q + 5'h01;
            end else if (bit_q == BIT_END) begin
              cs_n_q <= 1'b1;
              state_q <= H_SGAP;
            end else begin
              tx_q <= {tx_q[FRAME_W-2:0], 1'b0};
            end
          end
        end
        H_SGAP: begin
          bit_q <= 5'h00;
          if (div_q == HALF_LAST) begin
            div_q <= 4'h0;
            if (second_q) begin
              tx_q <= {ctrl_q[CTRL_READ], ctrl_q[CTRL_OFFS],
                       data_q[DATA_CHAN_LSB +: ADDR_W], 3'h0,
                       data_q[CODE_W-1:0]};
              cs_n_q <= 1'b0;
              second_q <= 1'b0;
              state_q <= H_SFRM;
            end else begin
              if (ctrl_q[CTRL_READ]) begin
                rdbk_q <= rx_q[FRAME_W-1 -: CODE_W];
              end
              state_q <= H_IDLE;
            end
          end
        end
      endcase
    end
  end

  // Parallel pins are released in serial mode and fall to their pulls.
  assign link.cs_sync_n = cs_n_q;
  assign link.wr_n_h = wr_n_q;
  assign link.sclk = sclk_q;
  assign link.sdin_h = tx_q[FRAME_W-1];
  assign link.interface_select = ctrl_q[CTRL_SERIAL];
  assign link.track = ctrl_q[CTRL_TRACK];
  assign link.channel_addr_h = data_q[DATA_CHAN_LSB +: ADDR_W];
  assign link.offset_sel_h = ctrl_q[CTRL_OFFS];
  assign link.acquire_all_h = all_q;
  assign link.addr_oe = !ctrl_q[CTRL_SERIAL];
  assign link.wr_oe = !ctrl_q[CTRL_SERIAL];
  assign link.offs_oe = !ctrl_q[CTRL_SERIAL];
  assign link.all_oe = !ctrl_q[CTRL_SERIAL];
  assign link.sdin_oe = ctrl_q[CTRL_SERIAL];
endmodule

// file: dac_pkg.sv
package dac_pkg;
  // Core clock.
  localparam int CLK_PERIOD_NS = 10;
  // Channel map.
  localparam int CHAN_N = 32;
  localparam int ADDR_W = 5;
  localparam int CHAN_W = 6;
  localparam int CODE_W = 14;
  localparam logic [5:0] OFFSET_CHAN = 6'h20;
  // Serial frame layout.
  localparam int FRAME_W = 24;
  localparam int READ_BIT = 23;
  localparam int OFFS_BIT = 22;
  localparam int ADDR_LSB = 17;
  localparam int BITCNT_W = 5;
  localparam logic [4:0] BIT_LAST = 5'h17;
  localparam logic [4:0] BIT_END = 5'h18;
  // Acquisition time of one input voltage.
  localparam int ACQ_TIME_NS = 2000;
  localparam int ACQ_CYCLES = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACQ_CNT_W = 8;
  localparam logic [7:0] ACQ_LAST = 8'(ACQ_CYCLES - 1);
  // Serial clock made by the host, well below the 14 MHz ceiling.
  localparam int SCLK_PERIOD_NS = 160;
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int DIV_W = 4;
  localparam logic [3:0] HALF_LAST = 4'(SCLK_HALF_CYC - 1);
  // Parallel write strobe width.
  localparam int STROBE_NS = 40;
  localparam logic [3:0] STROBE_LAST = 4'(STROBE_NS / CLK_PERIOD_NS - 1);
  // Positions of the link pins in the device's sampled pin vector.
  localparam int PIN_ADDR = 0;
  localparam int PIN_SDIN = 5;
  localparam int PIN_SCLK = 6;
  localparam int PIN_ALL = 7;
  localparam int PIN_OFFS = 8;
  localparam int PIN_WR_N = 9;
  localparam int PIN_CS_N = 10;
  localparam int PIN_TRACK = 11;
  localparam int PIN_SEL = 12;
  localparam int PIN_N = 13;
  localparam logic [12:0] PIN_IDLE = 13'h067F;
  // Host register map, byte addresses.
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_DATA = 5'h04;
  localparam logic [4:0] REG_STATUS = 5'h08;
  localparam logic [4:0] REG_MASK = 5'h0C;
  localparam logic [4:0] REG_RDBK = 5'h10;
  localparam int CTRL_SERIAL = 0;
  localparam int CTRL_TRACK = 1;
  localparam int CTRL_OFFS = 2;
  localparam int CTRL_ALL = 3;
  localparam int CTRL_READ = 4;
  localparam int CTRL_W = 5;
  localparam int CTRL_GO = 7;
  localparam int DATA_CHAN_LSB = 16;
  localparam int EVT_XFER = 0;
  localparam int EVT_ACQ = 1;
  localparam int EVT_W = 2;
  localparam int ST_RUN = 8;
  localparam int ST_LINK_BUSY = 9;
  localparam logic [12:0] CTRL_RESET = 13'h0000;
endpackage

// file: dac_link_if.sv
`timescale 1ns/10ps
interface dac_link_if;
  logic cs_sync_n;
  logic sclk;
  logic interface_select;
  logic track;
  logic busy_n;
  logic sdout;
  logic [4:0] channel_addr_h;
  logic addr_oe;
  logic sdin_h;
  logic sdin_oe;
  logic wr_n_h;
  logic wr_oe;
  logic offset_sel_h;
  logic offs_oe;
  logic acquire_all_h;
  logic all_oe;
  logic [4:0] channel_addr;
  logic sdin;
  logic wr_n;
  logic offset_sel;
  logic acquire_all;
  // Undriven pins fall to their internal pull level.
  assign channel_addr = addr_oe ? channel_addr_h : 5'h1F;
  assign sdin = sdin_oe ? sdin_h : 1'h1;
  assign wr_n = wr_oe ? wr_n_h : 1'h0;
  assign offset_sel = offs_oe ? offset_sel_h : 1'h0;
  assign acquire_all = all_oe ? acquire_all_h : 1'h0;
  modport dev (
    input cs_sync_n, sclk, interface_select, track, channel_addr, sdin,
    input wr_n, offset_sel, acquire_all,
    output busy_n, sdout
  );
  modport host (
    output cs_sync_n, sclk, interface_select, track, channel_addr_h,
    output addr_oe, sdin_h, sdin_oe, wr_n_h, wr_oe, offset_sel_h, offs_oe,
    output acquire_all_h, all_oe,
    input busy_n, sdout
  );
endinterface

// file: dac_device_end.sv
`timescale 1ns/10ps
// What this block does
// - Five address lines pick one of 32
// - Acquire-all input makes all 32 address channels acquire, not the offset channel
// - Shared low pin: select or frame sync
// - Host lowers write strobe with select
// - Offset select targets the offset channel
// - Host keeps serial clock within limits
// - Serial input sampled on falling clock
// - Readback changes on rising clock edges
// - Interface select low parallel, high serial
// - Busy low throughout each acquisition
// - Track high acquires once channel addressed
// - Floating pins settle to their pull levels
module dac_device_end (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // Link pins
  dac_link_if.dev link,
  // Digitised analog input voltage
  input wire logic [dac_pkg::CODE_W-1:0] i_vin_code,
  // Channel register updates
  output logic o_update_valid,
  output logic [dac_pkg::CHAN_W-1:0] o_update_chan,
  output logic [dac_pkg::CODE_W-1:0] o_update_code
);
  import dac_pkg::*;

  typedef enum logic [1:0] {
    ACQ_IDLE = 2'b01,
    ACQ_RUN = 2'b10
  } acq_state_t;

  logic [PIN_N-1:0] pin_raw;
  logic [PIN_N-1:0] meta_q;
  logic [PIN_N-1:0] pin_q;
  logic [PIN_N-1:0] last_q;
  logic serial_sel;
  logic strobe;
  logic strobe_last;
  logic strobe_rise;
  logic strobe_fall;
  logic all_rise;
  logic frame;
  logic frame_start;
  logic sclk_fall;
  logic sclk_rise;
  logic frame_done;
  logic [FRAME_W-1:0] word;
  logic [CHAN_W-1:0] par_chan;
  logic [CHAN_W-1:0] ser_chan;
  logic acq_start;
  logic acq_end;
  logic ser_write;
  acq_state_t acq_state_q;
  logic [ACQ_CNT_W-1:0] acq_cnt_q;
  logic [CHAN_W-1:0] acq_chan_q;
  logic acq_all_q;
  logic busy_n_q;
  logic [CHAN_W-1:0] hold_chan_q;
  logic [FRAME_W-1:0] in_sr_q;
  logic [FRAME_W-1:0] out_sr_q;
  logic [BITCNT_W-1:0] bit_cnt_q;
  logic [CHAN_W-1:0] rb_ptr_q;
  logic [CODE_W-1:0] code_q [0:CHAN_N];

  // The pull levels themselves live in the link wiring.
  assign pin_raw = {link.interface_select, link.track, link.cs_sync_n,
                    link.wr_n, link.offset_sel, link.acquire_all, link.sclk,
                    link.sdin, link.channel_addr};

  // Every pin is asynchronous to the core clock, so two flops come first.
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      meta_q <= PIN_IDLE;
      pin_q <= PIN_IDLE;
      last_q <= PIN_IDLE;
    end else begin
      meta_q <= pin_raw;
      pin_q <= meta_q;
      last_q <= pin_q;
    end
  end

  assign serial_sel = pin_q[PIN_SEL];
  // Parallel pins only count while the parallel interface is chosen.
  assign strobe = !serial_sel && !pin_q[PIN_CS_N] && !pin_q[PIN_WR_N];
  assign strobe_last = !last_q[PIN_SEL] && !last_q[PIN_CS_N]
                       && !last_q[PIN_WR_N];
  assign strobe_rise = strobe && !strobe_last;
  assign strobe_fall = !strobe && strobe_last;
  assign all_rise = !serial_sel && pin_q[PIN_ALL] && !last_q[PIN_ALL];
  // The same low pin frames serial words when serial is chosen.
  assign frame = serial_sel && !pin_q[PIN_CS_N];
  assign frame_start = frame && last_q[PIN_CS_N];
  assign sclk_fall = frame && last_q[PIN_SCLK] && !pin_q[PIN_SCLK];
  assign sclk_rise = frame && !last_q[PIN_SCLK] && pin_q[PIN_SCLK];
  assign frame_done = sclk_fall && bit_cnt_q == BIT_LAST;
  assign word = {in_sr_q[FRAME_W-2:0], pin_q[PIN_SDIN]};
  assign par_chan = pin_q[PIN_OFFS] ? OFFSET_CHAN
                    : {1'b0, pin_q[PIN_ADDR +: ADDR_W]};
  assign ser_chan = word[OFFS_BIT] ? OFFSET_CHAN
                    : {1'b0, word[ADDR_LSB +: ADDR_W]};
  assign ser_write = frame_done && !word[READ_BIT];

  // With track low the channel acquires when its strobe ends.
  assign acq_start = acq_state_q == ACQ_IDLE
                     && (all_rise || (pin_q[PIN_TRACK] ? strobe_rise
                                                       : strobe_fall));
  assign acq_end = acq_state_q == ACQ_RUN && acq_cnt_q == ACQ_LAST;

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      hold_chan_q <= 6'h00;
    end else if (strobe_rise) begin
      hold_chan_q <= par_chan;
    end
  end

  // Requests that arrive during an acquisition are dropped.
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      acq_state_q <= ACQ_IDLE;
      acq_cnt_q <= 8'h00;
      acq_chan_q <= 6'h00;
      acq_all_q <= 1'b0;
      busy_n_q <= 1'b1;
    end else begin
      unique case (acq_state_q)
        ACQ_IDLE: begin
          acq_cnt_q <= 8'h00;
          if (acq_start) begin
            acq_state_q <= ACQ_RUN;
            acq_all_q <= all_rise;
            acq_chan_q <= pin_q[PIN_TRACK] ? par_chan : hold_chan_q;
            busy_n_q <= 1'b0;
          end
        end
        ACQ_RUN: begin
          acq_cnt_q <= acq_cnt_q + 8'h01;
          if (acq_end) begin
            acq_state_q <= ACQ_IDLE;
            busy_n_q <= 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      in_sr_q <= 24'h000000;
      bit_cnt_q <= 5'h00;
    end else if (frame_start) begin
      bit_cnt_q <= 5'h00;
    end else if (sclk_fall && bit_cnt_q != BIT_END) begin
      in_sr_q <= word;
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  // A read command aims the next frame's readback at a channel.
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      rb_ptr_q <= 6'h00;
    end else if (frame_done && word[READ_BIT]) begin
      rb_ptr_q <= ser_chan;
    end
  end

  // The first bit must be out before the first falling edge, so the
  // register is loaded when the frame opens and shifted on rising edges.
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      out_sr_q <= 24'h000000;
    end else if (frame_start) begin
      out_sr_q <= {code_q[rb_ptr_q], {(FRAME_W - CODE_W){1'b0}}};
    end else if (sclk_rise) begin
      out_sr_q <= {out_sr_q[FRAME_W-2:0], 1'b0};
    end
  end

  // Acquisition wins the cycle; a serial write then is dropped.
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      for (int i = 0; i <= CHAN_N; i++) begin
        code_q[i] <= 14'h0000;
      end
    end else if (acq_end && acq_all_q) begin
      for (int i = 0; i < CHAN_N; i++) begin
        code_q[i] <= i_vin_code;
      end
    end else if (acq_end) begin
      code_q[acq_chan_q] <= i_vin_code;
    end else if (ser_write) begin
      code_q[ser_chan] <= word[CODE_W-1:0];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      o_update_valid <= 1'b0;
      o_update_chan <= 6'h00;
      o_update_code <= 14'h0000;
    end else begin
      o_update_valid <= acq_end || ser_write;
      if (acq_end) begin
        o_update_chan <= acq_all_q ? 6'h3F : acq_chan_q;
        o_update_code <= i_vin_code;
      end else if (ser_write) begin
        o_update_chan <= ser_chan;
        o_update_code <= word[CODE_W-1:0];
      end
    end
  end

  assign link.busy_n = busy_n_q;
  assign link.sdout = out_sr_q[FRAME_W-1];
endmodule

// file: dac_link_sva.sv
`timescale 1ns/10ps
module dac_link_sva (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_reset,
  // Link signals
  input wire logic cs_sync_n,
  input wire logic sclk,
  input wire logic interface_select,
  input wire logic track,
  input wire logic busy_n,
  input wire logic sdout,
  input wire logic sdin,
  input wire logic sdin_oe,
  input wire logic addr_oe,
  input wire logic wr_n_h,
  input wire logic wr_oe,
  input wire logic offset_sel_h
);
  import dac_pkg::*;
  // A counter keeps the long busy window out of the property engine.
  logic [8:0] busy_cnt_q;
  always_ff @(posedge i_core_clk) begin
    if (i_reset || busy_n) begin
      busy_cnt_q <= 9'h000;
    end else begin
      busy_cnt_q <= busy_cnt_q + 9'h001;
    end
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  busy_len_a: assert property ($rose(busy_n) |->
    busy_cnt_q >= 9'(ACQ_CYCLES - 1) && busy_cnt_q <= 9'(ACQ_CYCLES + 1))
    else $error("busy window length wrong");
  busy_start_a: assert property (!interface_select && track && busy_n &&
    wr_oe && $fell(wr_n_h) |-> ##[2:6] !busy_n)
    else $error("busy did not fall after strobe");
  strobe_cs_a: assert property (wr_oe && !wr_n_h |-> !cs_sync_n)
    else $error("strobe without select");
  strobe_len_a: assert property ($fell(wr_n_h) |-> !wr_n_h[*4] ##1 wr_n_h)
    else $error("strobe width wrong");
  sclk_idle_a: assert property (cs_sync_n |-> sclk)
    else $error("serial clock not idle high");
  sclk_low_a: assert property ($fell(sclk) |-> !sclk[*8] ##1 sclk)
    else $error("serial clock low phase wrong");
  sdin_hold_a: assert property ($fell(sclk) |-> $stable(sdin))
    else $error("serial data moved at falling edge");
  sdout_edge_a: assert property ($changed(sdout) && !cs_sync_n &&
    interface_select |-> sclk)
    else $error("readback changed while clock low");
  mode_oe_a: assert property ($stable(interface_select) &&
    interface_select |-> sdin_oe && !wr_oe && !addr_oe)
    else $error("pin enables disagree with mode");
  cover property ($fell(busy_n));
  cover property ($fell(sclk) && interface_select);
  cover property ($fell(wr_n_h) && offset_sel_h);
endmodule

// file: tb_multichannel_dac_host_port.sv
`timescale 1ns/10ps
module tb_multichannel_dac_host_port;
  import dac_pkg::*;
  logic i_core_clk = 1'b0;
  logic i_reset = 1'b1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h00000000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic [CODE_W-1:0] vin_code = 14'h0000;
  logic upd_valid;
  logic [CHAN_W-1:0] upd_chan;
  logic [CODE_W-1:0] upd_code;
  int num_errors = 0;
  int samples_checked = 0;
  always #(CLK_PERIOD_NS / 2) i_core_clk = ~i_core_clk;
  dac_link_if link ();
  dac_device_end i_dac_device_end (.i_core_clk(i_core_clk),
    .i_reset(i_reset), .link(link.dev), .i_vin_code(vin_code),
    .o_update_valid(upd_valid), .o_update_chan(upd_chan),
    .o_update_code(upd_code));
  dac_host_end i_dac_host_end (.i_core_clk(i_core_clk), .i_reset(i_reset),
    .i_avs_address(avs_address), .i_avs_read(avs_read),
    .i_avs_write(avs_write), .i_avs_writedata(avs_writedata),
    .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest),
    .o_irq(irq), .link(link.host));
  dac_link_sva i_dac_link_sva (.i_core_clk(i_core_clk), .i_reset(i_reset),
    .cs_sync_n(link.cs_sync_n), .sclk(link.sclk),
    .interface_select(link.interface_select), .track(link.track),
    .busy_n(link.busy_n), .sdout(link.sdout), .sdin(link.sdin),
    .sdin_oe(link.sdin_oe), .addr_oe(link.addr_oe), .wr_n_h(link.wr_n_h),
    .wr_oe(link.wr_oe), .offset_sel_h(link.offset_sel_h));
  task finish_test;
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task av_write(input logic [4:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    @(posedge i_core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge i_core_clk);
    avs_write <= 1'b0;
  endtask
  task av_read(input logic [4:0] a, output logic [31:0] d);
    @(posedge i_core_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge i_core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge i_core_clk);
    d = avs_readdata;
    avs_read <= 1'b0;
  endtask
  // Status reads clear the sticky bits, so every read is folded into acc.
  task wait_evt(input int b, output logic [31:0] acc);
    logic [31:0] s;
    acc = 32'h00000000;
    s = 32'h00000100;
    for (int i = 0; i < 300; i++) begin
      if (acc[b] === 1'b1 && s[ST_RUN] === 1'b0) break;
      av_read(REG_STATUS, s);
      acc |= s;
    end
  endtask
  task wait_upd(output logic [CHAN_W-1:0] ch, output logic [CODE_W-1:0] cd);
    ch = 6'h00;
    cd = 14'h0000;
    for (int i = 0; i < 3000; i++) begin
      @(posedge i_core_clk);
      if (upd_valid === 1'b1) begin
        ch = upd_chan;
        cd = upd_code;
        break;
      end
    end
  endtask
  task par_op(input logic [31:0] ctrl, input logic [4:0] ch,
      input logic [CODE_W-1:0] v, input logic [CHAN_W-1:0] exp_ch);
    logic [CHAN_W-1:0] c;
    logic [CODE_W-1:0] d;
    logic [31:0] st;
    vin_code <= v;
    av_write(REG_DATA, {11'h000, ch, 16'h0000});
    av_write(REG_CTRL, ctrl | 32'h00000080);
    wait_upd(c, d);
    check("update chan", 32'(exp_ch), 32'(c));
    check("update code", 32'(v), 32'(d));
    wait_evt(EVT_ACQ, st);
    check("status events", 32'h00000003, st & 32'h00000003);
  endtask
  task t_par_track;
    par_op(32'h00000002, 5'h00, 14'h1234, 6'h00);
  endtask
  task t_par_hold;
    par_op(32'h00000000, 5'h1F, 14'h3FFF, 6'h1F);
  endtask
  task t_par_offset;
    par_op(32'h00000006, 5'h03, 14'h0555, OFFSET_CHAN);
  endtask
  task t_par_all;
    par_op(32'h0000000A, 5'h07, 14'h2AAA, 6'h3F);
  endtask
  task t_ser_write;
    logic [CHAN_W-1:0] c;
    logic [CODE_W-1:0] d;
    logic [31:0] st;
    av_write(REG_MASK, 32'h00000001);
    av_write(REG_DATA, {11'h000, 5'h09, 2'h0, 14'h2ABC});
    av_write(REG_CTRL, 32'h00000081);
    wait_upd(c, d);
    check("serial chan", 32'h00000009, 32'(c));
    check("serial code", 32'h00002ABC, 32'(d));
    for (int i = 0; i < 500 && irq !== 1'b1; i++) @(posedge i_core_clk);
    check("irq raised", 32'h00000001, 32'(irq));
    av_read(REG_STATUS, st);
    check("xfer done", 32'h00000001, st & 32'h00000003);
    repeat (3) @(posedge i_core_clk);
    check("irq cleared", 32'h00000000, 32'(irq));
    av_write(REG_MASK, 32'h00000000);
    av_read(REG_MASK, st);
    check("mask readback", 32'h00000000, st & 32'h00000003);
  endtask
  task t_ser_read(input logic [4:0] ch, input logic [CODE_W-1:0] exp);
    logic [31:0] st;
    av_write(REG_DATA, {11'h000, ch, 16'h0000});
    av_write(REG_CTRL, 32'h00000091);
    wait_evt(EVT_XFER, st);
    av_read(REG_RDBK, st);
    check("readback", 32'(exp), st & 32'h00003FFF);
  endtask
  task t_unmapped;
    logic [31:0] st;
    av_read(5'h14, st);
    check("unmapped read", 32'h00000000, st);
  endtask
  initial begin
    #(CLK_PERIOD_NS * 30000);
    num_errors++;
    finish_test();
  end
  initial begin
    repeat (10) @(posedge i_core_clk);
    check("reset busy", 32'h00000001, 32'(link.busy_n));
    check("reset select", 32'h00000001, 32'(link.cs_sync_n));
    check("reset mode", 32'h00000000, 32'(link.interface_select));
    check("reset wait", 32'h00000001, 32'(avs_waitrequest));
    i_reset <= 1'b0;
    repeat (4) @(posedge i_core_clk);
    t_par_track();
    t_par_hold();
    t_par_offset();
    t_par_all();
    t_ser_write();
    t_ser_read(5'h09, 14'h2ABC);
    t_ser_read(5'h1F, 14'h2AAA);
    t_unmapped();
    finish_test();
  end
endmodule
